/* File: rtl/eq_pins_pkg.sv */
package eq_pins_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    // register offsets
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_STATUS = 8'h04;
    localparam logic [7:0] OFS_IRQ_STAT = 8'h08;
    localparam logic [7:0] OFS_IRQ_MASK = 8'h0C;
    localparam logic [7:0] OFS_RESTARTS = 8'h10;
    // control fields
    localparam int CTRL_RESTART_BIT = 0;
    localparam int CTRL_HOLD_BIT = 1;
    localparam int CTRL_W = 2;
    localparam logic [1:0] CTRL_RST = 2'h0;
    // status fields
    localparam int ST_CHROMA_BIT = 0;
    localparam int ST_POL_BIT = 1;
    localparam int ST_LOCK_BIT = 2;
    localparam int ST_CHROMA_FORCED_BIT = 3;
    localparam int ST_POL_FORCED_BIT = 4;
    localparam int ST_HOLD_BIT = 5;
    localparam int ST_BYPASS_BIT = 6;
    localparam int ST_STATE_LSB = 8;
    // event bits
    localparam int EVT_N = 4;
    localparam int EVT_LOCK_GAIN = 0;
    localparam int EVT_LOCK_LOSS = 1;
    localparam int EVT_REACQ = 2;
    localparam int EVT_CHROMA = 3;
    localparam logic [3:0] IRQ_MASK_RST = 4'h0;
    localparam logic [7:0] RESTARTS_RST = 8'h00;
    // settle timing
    localparam int CLK_MHZ = 25;
    localparam int SETTLE_TIME_NS = 4000;
    localparam int SETTLE_CYCLES = (SETTLE_TIME_NS * CLK_MHZ + 999) / 1000;
    localparam int SETTLE_CNT_W = 8;
    localparam logic [7:0] SETTLE_LAST = 8'(SETTLE_CYCLES - 1);
    // acquisition states
    typedef enum logic [4:0] {
        ST_NOSIG = 5'h01,
        ST_ACQUIRE = 5'h02,
        ST_SETTLE = 5'h04,
        ST_EQ_SETTLED_STATUS = 5'h08,
        ST_BYPASS = 5'h10
    } acq_state_e;
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic wr;
        logic rd;
    } bus_req_s;
    typedef struct packed {
        logic level;
        logic forced;
    } pin_in_s;
    typedef struct packed {
        logic value;
        logic weak_oe;
    } pin_out_s;
    typedef struct packed {
        logic signal_present;
        logic burst_seen;
        logic inverted_seen;
        logic adapt_done;
    } core_in_s;
    typedef struct packed {
        logic color_mode;
        logic invert_chain;
        logic adapt_en;
        logic restart;
        logic bypass;
    } core_out_s;
endpackage : eq_pins_pkg

/* File: rtl/pin_pulse_detect.sv */
`timescale 1ns/1ns
module pin_pulse_detect (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // sensed pin
    input wire logic enable,
    input wire logic level,
    // result
    output logic pulse
);
    logic armed_reg;
    logic start_reg;
    logic moved_reg;

    // track departure from and return to the starting level
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            armed_reg <= 1'b0;
            start_reg <= 1'b0;
            moved_reg <= 1'b0;
            pulse <= 1'b0;
        end else begin
            pulse <= 1'b0;
            if (!enable) begin
                armed_reg <= 1'b0;
                moved_reg <= 1'b0;
            end else if (!armed_reg) begin
                armed_reg <= 1'b1;
                start_reg <= level;
                moved_reg <= 1'b0;
            end else if (level != start_reg) begin
                moved_reg <= 1'b1;
            end else if (moved_reg) begin
                pulse <= 1'b1;
                moved_reg <= 1'b0;
            end
        end
    end
endmodule : pin_pulse_detect

/* File: rtl/event_status.sv */
`timescale 1ns/1ns
module event_status #(
    parameter int N = 4
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // events and software access
    input wire logic [N-1:0] set,
    input wire logic clr_wr,
    input wire logic [N-1:0] clr_data,
    input wire logic mask_wr,
    input wire logic [N-1:0] mask_data,
    // state
    output logic [N-1:0] status,
    output logic [N-1:0] mask,
    output logic irq
);
    logic [N-1:0] status_next;
    logic [N-1:0] mask_next;

    // sticky bits, a new event beats a write-one clear
    for (genvar i = 0; i < N; i++) begin : g_bit
        assign status_next[i] = set[i] | (status[i] & ~(clr_wr & clr_data[i]));
    end
    assign mask_next = mask_wr ? mask_data : mask;

    // status and mask storage
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            status <= '0;
            mask <= eq_pins_pkg::IRQ_MASK_RST;
        end else begin
            status <= status_next;
            mask <= mask_next;
        end
    end

    // level interrupt aligned with the stored bits
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            irq <= 1'b0;
        end else begin
            irq <= |(status_next & mask_next);
        end
    end
endmodule : event_status

/* File: rtl/eq_pin_control.sv */
`timescale 1ns/1ns
module eq_pin_control (
    // clock and reset
    input wire logic SYS_CLK,
    input wire logic RESET_N,
    // register port
    input wire eq_pins_pkg::bus_req_s BUS_REQ,
    output logic [eq_pins_pkg::DATA_W-1:0] BUS_RDATA,
    output logic IRQ,
    // chroma indicator pin
    input wire eq_pins_pkg::pin_in_s CHROMA_PIN_IN,
    output eq_pins_pkg::pin_out_s CHROMA_PIN_OUT,
    // polarity indicator pin
    input wire eq_pins_pkg::pin_in_s POLARITY_PIN_IN,
    output eq_pins_pkg::pin_out_s POLARITY_PIN_OUT,
    // lock, hold and bypass pins
    output logic EQ_SETTLED_STATUS,
    input wire logic HOLD_IN,
    input wire logic EQUALIZER_BYPASS,
    // serial interface pins
    input wire logic SERIAL_SELECT,
    input wire logic SERIAL_CLK,
    input wire logic SERIAL_DATA_IN,
    output logic SERIAL_DATA_OUT,
    output logic SERIAL_DATA_OE,
    // analog equalizer core
    input wire eq_pins_pkg::core_in_s CORE_IN,
    output eq_pins_pkg::core_out_s CORE_OUT
);
    eq_pins_pkg::acq_state_e state_reg;
    eq_pins_pkg::acq_state_e state_next;
    logic [eq_pins_pkg::SETTLE_CNT_W-1:0] settle_cnt_reg;
    logic [eq_pins_pkg::CTRL_W-1:0] ctrl_reg;
    logic [7:0] restarts_reg;
    logic chroma_reg;
    logic polarity_reg;
    logic color_mode_next;
    logic invert_next;
    logic hold_active;
    logic standalone;
    logic pol_pulse;
    logic sw_restart;
    logic restart;
    logic eq_settled_status_now;
    logic eq_settled_status_prev_reg;
    logic color_prev_reg;
    logic [eq_pins_pkg::EVT_N-1:0] events;
    logic [eq_pins_pkg::EVT_N-1:0] irq_status;
    logic [eq_pins_pkg::EVT_N-1:0] irq_mask;
    logic irq_wr;
    logic mask_wr;
    logic ctrl_wr;
    logic serial_idle_reg;
    logic [eq_pins_pkg::DATA_W-1:0] status_word;

    // register write decode
    assign ctrl_wr = BUS_REQ.wr && (BUS_REQ.addr == eq_pins_pkg::OFS_CTRL);
    assign irq_wr = BUS_REQ.wr && (BUS_REQ.addr == eq_pins_pkg::OFS_IRQ_STAT);
    assign mask_wr = BUS_REQ.wr && (BUS_REQ.addr == eq_pins_pkg::OFS_IRQ_MASK);
    assign sw_restart = ctrl_wr && BUS_REQ.wdata[eq_pins_pkg::CTRL_RESTART_BIT];

    // stand-alone when the serial interface sits idle
    assign standalone = serial_idle_reg;

    // hold comes from the pin or from software
    assign hold_active = HOLD_IN | ctrl_reg[eq_pins_pkg::CTRL_HOLD_BIT];

    // any restart source sends acquisition back to its start
    assign restart = pol_pulse | sw_restart;

    // lock decode
    assign eq_settled_status_now = (state_reg == eq_pins_pkg::ST_EQ_SETTLED_STATUS);

    // mode selection, an external drive beats the detector
    assign color_mode_next = CHROMA_PIN_IN.forced ? CHROMA_PIN_IN.level
                                                  : CORE_IN.burst_seen;
    assign invert_next = POLARITY_PIN_IN.forced ? POLARITY_PIN_IN.level
                                                : CORE_IN.inverted_seen;

    // control register, restart bit reads back as zero
    always_ff @(posedge SYS_CLK) begin
        if (!RESET_N) begin
            ctrl_reg <= eq_pins_pkg::CTRL_RST;
        end else begin
            if (ctrl_wr) begin
                ctrl_reg[eq_pins_pkg::CTRL_HOLD_BIT] <=
                    BUS_REQ.wdata[eq_pins_pkg::CTRL_HOLD_BIT];
            end
            ctrl_reg[eq_pins_pkg::CTRL_RESTART_BIT] <= 1'b0;
        end
    end

    // serial pins held low mark the interface unused
    always_ff @(posedge SYS_CLK) begin
        if (!RESET_N) begin
            serial_idle_reg <= 1'b1;
        end else begin
            serial_idle_reg <= !SERIAL_SELECT && !SERIAL_CLK && !SERIAL_DATA_IN;
        end
    end

    // serial data is never driven by this logic
    always_ff @(posedge SYS_CLK) begin
        if (!RESET_N) begin
            SERIAL_DATA_OUT <= 1'b0;
            SERIAL_DATA_OE <= 1'b0;
        end else begin
            SERIAL_DATA_OUT <= 1'b0;
            SERIAL_DATA_OE <= 1'b0;
        end
    end

    // full pulse on the forced polarity pin
    pin_pulse_detect u_pol_pulse (
        .clk(SYS_CLK),
        .rst_n(RESET_N),
        .enable(standalone && POLARITY_PIN_IN.forced),
        .level(POLARITY_PIN_IN.level),
        .pulse(pol_pulse)
    );

    // acquisition state transitions
    always_comb begin
        state_next = state_reg;
        if (EQUALIZER_BYPASS) begin
            state_next = eq_pins_pkg::ST_BYPASS;
        end else if (restart) begin
            state_next = eq_pins_pkg::ST_ACQUIRE;
        end else if (!hold_active) begin
            unique case (state_reg)
                eq_pins_pkg::ST_NOSIG: begin
                    if (CORE_IN.signal_present) begin
                        state_next = eq_pins_pkg::ST_ACQUIRE;
                    end
                end
                eq_pins_pkg::ST_ACQUIRE: begin
                    if (!CORE_IN.signal_present) begin
                        state_next = eq_pins_pkg::ST_NOSIG;
                    end else if (CORE_IN.adapt_done) begin
                        state_next = eq_pins_pkg::ST_SETTLE;
                    end
                end
                eq_pins_pkg::ST_SETTLE: begin
                    if (!CORE_IN.signal_present) begin
                        state_next = eq_pins_pkg::ST_NOSIG;
                    end else if (!CORE_IN.adapt_done) begin
                        state_next = eq_pins_pkg::ST_ACQUIRE;
                    end else if (settle_cnt_reg == eq_pins_pkg::SETTLE_LAST) begin
                        state_next = eq_pins_pkg::ST_EQ_SETTLED_STATUS;
                    end
                end
                eq_pins_pkg::ST_EQ_SETTLED_STATUS: begin
                    if (!CORE_IN.signal_present) begin
                        state_next = eq_pins_pkg::ST_NOSIG;
                    end else if (!CORE_IN.adapt_done) begin
                        state_next = eq_pins_pkg::ST_ACQUIRE;
                    end
                end
                eq_pins_pkg::ST_BYPASS: begin
                    state_next = eq_pins_pkg::ST_NOSIG;
                end
            endcase
        end
    end

    // acquisition state register
    always_ff @(posedge SYS_CLK) begin
        if (!RESET_N) begin
            state_reg <= eq_pins_pkg::ST_NOSIG;
        end else begin
            state_reg <= state_next;
        end
    end

    // settle timer runs only while settling
    always_ff @(posedge SYS_CLK) begin
        if (!RESET_N) begin
            settle_cnt_reg <= '0;
        end else if (state_next != eq_pins_pkg::ST_SETTLE) begin
            settle_cnt_reg <= '0;
        end else if (state_reg == eq_pins_pkg::ST_SETTLE && !hold_active) begin
            settle_cnt_reg <= settle_cnt_reg + 8'h01;
        end
    end

    // restart counter, saturating
    always_ff @(posedge SYS_CLK) begin
        if (!RESET_N) begin
            restarts_reg <= eq_pins_pkg::RESTARTS_RST;
        end else if (restart && !EQUALIZER_BYPASS && restarts_reg != 8'hFF) begin
            restarts_reg <= restarts_reg + 8'h01;
        end
    end

    // detector snapshots for the status word
    always_ff @(posedge SYS_CLK) begin
        if (!RESET_N) begin
            chroma_reg <= 1'b0;
            polarity_reg <= 1'b0;
        end else begin
            chroma_reg <= CORE_IN.burst_seen;
            polarity_reg <= CORE_IN.inverted_seen;
        end
    end

    // chroma pin, weak drive whenever nobody forces it
    always_ff @(posedge SYS_CLK) begin
        if (!RESET_N) begin
            CHROMA_PIN_OUT <= '0;
        end else begin
            CHROMA_PIN_OUT.value <= CORE_IN.burst_seen;
            CHROMA_PIN_OUT.weak_oe <= !CHROMA_PIN_IN.forced;
        end
    end

    // polarity pin, weak drive whenever nobody forces it
    always_ff @(posedge SYS_CLK) begin
        if (!RESET_N) begin
            POLARITY_PIN_OUT <= '0;
        end else begin
            POLARITY_PIN_OUT.value <= CORE_IN.inverted_seen;
            POLARITY_PIN_OUT.weak_oe <= !POLARITY_PIN_IN.forced;
        end
    end

    // lock output follows the settled state
    always_ff @(posedge SYS_CLK) begin
        if (!RESET_N) begin
            EQ_SETTLED_STATUS <= 1'b0;
        end else begin
            EQ_SETTLED_STATUS <= (state_next == eq_pins_pkg::ST_EQ_SETTLED_STATUS);
        end
    end

    // commands toward the analog core
    always_ff @(posedge SYS_CLK) begin
        if (!RESET_N) begin
            CORE_OUT <= '0;
        end else begin
            CORE_OUT.color_mode <= color_mode_next;
            CORE_OUT.invert_chain <= invert_next;
            CORE_OUT.adapt_en <= !hold_active && !EQUALIZER_BYPASS;
            CORE_OUT.restart <= restart && !EQUALIZER_BYPASS;
            CORE_OUT.bypass <= EQUALIZER_BYPASS;
        end
    end

    // history for edge events
    always_ff @(posedge SYS_CLK) begin
        if (!RESET_N) begin
            eq_settled_status_prev_reg <= 1'b0;
            color_prev_reg <= color_mode_next; // no false change event after reset
        end else begin
            eq_settled_status_prev_reg <= eq_settled_status_now;
            color_prev_reg <= color_mode_next;
        end
    end

    // event sources
    always_comb begin
        events = '0;
        events[eq_pins_pkg::EVT_LOCK_GAIN] = eq_settled_status_now && !eq_settled_status_prev_reg;
        events[eq_pins_pkg::EVT_LOCK_LOSS] = !eq_settled_status_now && eq_settled_status_prev_reg;
        events[eq_pins_pkg::EVT_REACQ] = pol_pulse;
        events[eq_pins_pkg::EVT_CHROMA] = color_mode_next != color_prev_reg;
    end

    // sticky status, mask and interrupt
    event_status #(
        .N(eq_pins_pkg::EVT_N)
    ) u_events (
        .clk(SYS_CLK),
        .rst_n(RESET_N),
        .set(events),
        .clr_wr(irq_wr),
        .clr_data(BUS_REQ.wdata[eq_pins_pkg::EVT_N-1:0]),
        .mask_wr(mask_wr),
        .mask_data(BUS_REQ.wdata[eq_pins_pkg::EVT_N-1:0]),
        .status(irq_status),
        .mask(irq_mask),
        .irq(IRQ)
    );

    // live status word
    always_comb begin
        status_word = '0;
        status_word[eq_pins_pkg::ST_CHROMA_BIT] = chroma_reg;
        status_word[eq_pins_pkg::ST_POL_BIT] = polarity_reg;
        status_word[eq_pins_pkg::ST_LOCK_BIT] = eq_settled_status_now;
        status_word[eq_pins_pkg::ST_CHROMA_FORCED_BIT] = CHROMA_PIN_IN.forced;
        status_word[eq_pins_pkg::ST_POL_FORCED_BIT] = POLARITY_PIN_IN.forced;
        status_word[eq_pins_pkg::ST_HOLD_BIT] = hold_active;
        status_word[eq_pins_pkg::ST_BYPASS_BIT] = EQUALIZER_BYPASS;
        status_word[eq_pins_pkg::ST_STATE_LSB +: 5] = state_reg;
    end

    // read data one cycle after the strobe, zero otherwise
    always_ff @(posedge SYS_CLK) begin
        if (!RESET_N) begin
            BUS_RDATA <= '0;
        end else if (BUS_REQ.rd) begin
            unique case (BUS_REQ.addr)
                eq_pins_pkg::OFS_CTRL: BUS_RDATA <= {30'h0, ctrl_reg};
                eq_pins_pkg::OFS_STATUS: BUS_RDATA <= status_word;
                eq_pins_pkg::OFS_IRQ_STAT: BUS_RDATA <= {28'h0, irq_status};
                eq_pins_pkg::OFS_IRQ_MASK: BUS_RDATA <= {28'h0, irq_mask};
                eq_pins_pkg::OFS_RESTARTS: BUS_RDATA <= {24'h0, restarts_reg};
                default: BUS_RDATA <= '0;
            endcase
        end else begin
            BUS_RDATA <= '0;
        end
    end
endmodule : eq_pin_control

/* File: test/eq_pin_control_properties.sv */
`timescale 1ns/1ns
module eq_pin_control_properties (
    // clock and reset
    input wire logic SYS_CLK,
    input wire logic RESET_N,
    // register port
    input wire eq_pins_pkg::bus_req_s BUS_REQ,
    // indicator pins
    input wire eq_pins_pkg::pin_in_s CHROMA_PIN_IN,
    input wire eq_pins_pkg::pin_out_s CHROMA_PIN_OUT,
    input wire eq_pins_pkg::pin_in_s POLARITY_PIN_IN,
    input wire eq_pins_pkg::pin_out_s POLARITY_PIN_OUT,
    // lock, hold, bypass and serial pins
    input wire logic EQ_SETTLED_STATUS,
    input wire logic HOLD_IN,
    input wire logic EQUALIZER_BYPASS,
    input wire logic SERIAL_SELECT,
    input wire logic SERIAL_CLK,
    input wire logic SERIAL_DATA_IN,
    // equalizer core
    input wire eq_pins_pkg::core_in_s CORE_IN,
    input wire eq_pins_pkg::core_out_s CORE_OUT
);
    logic [7:0] run_reg;
    logic sa;
    logic pf;
    logic pl;
    logic sw_hold_reg;
    // stand-alone strap and polarity pin shorthands
    assign sa = !(SERIAL_SELECT || SERIAL_CLK || SERIAL_DATA_IN);
    assign pf = POLARITY_PIN_IN.forced;
    assign pl = POLARITY_PIN_IN.level;
    // cycles of uninterrupted adaptation, saturating
    always_ff @(posedge SYS_CLK) begin
        if (!RESET_N || !CORE_IN.adapt_done || !CORE_IN.signal_present || EQUALIZER_BYPASS) begin
            run_reg <= 8'h00;
        end else if (run_reg != 8'hFF) begin
            run_reg <= run_reg + 8'h01;
        end
    end
    // software hold bit as last written
    always_ff @(posedge SYS_CLK) begin
        if (!RESET_N) begin
            sw_hold_reg <= 1'b0;
        end else if (BUS_REQ.wr && BUS_REQ.addr == eq_pins_pkg::OFS_CTRL) begin
            sw_hold_reg <= BUS_REQ.wdata[eq_pins_pkg::CTRL_HOLD_BIT];
        end
    end
    default clocking @(posedge SYS_CLK); endclocking
    default disable iff (!RESET_N);
    a_chroma_pin_out: assert property ($past(RESET_N) |->
        CHROMA_PIN_OUT.value == $past(CORE_IN.burst_seen)
        && CHROMA_PIN_OUT.weak_oe == !$past(CHROMA_PIN_IN.forced)) else $error("chroma pin out");
    a_polarity_pin_out: assert property ($past(RESET_N) |->
        POLARITY_PIN_OUT.value == $past(CORE_IN.inverted_seen)
        && POLARITY_PIN_OUT.weak_oe == !$past(pf)) else $error("polarity pin out");
    a_color_force: assert property ($past(RESET_N) && $past(CHROMA_PIN_IN.forced) |->
        CORE_OUT.color_mode == $past(CHROMA_PIN_IN.level)) else $error("color mode not forced");
    a_invert_force: assert property ($past(RESET_N) && $past(pf) |->
        CORE_OUT.invert_chain == $past(pl)) else $error("inversion not forced");
    a_lock_after_settle: assert property ($rose(EQ_SETTLED_STATUS) |->
        run_reg >= eq_pins_pkg::SETTLE_CYCLES) else $error("lock before settle time");
    a_lock_no_signal: assert property (!CORE_IN.signal_present && !HOLD_IN
        && !sw_hold_reg |=> !EQ_SETTLED_STATUS) else $error("lock without signal");
    a_hold_keeps_lock: assert property (HOLD_IN && EQ_SETTLED_STATUS && !EQUALIZER_BYPASS
        && CORE_IN.signal_present && !BUS_REQ.wr && !$past(BUS_REQ.wr) && !pf && !$past(pf)
        |=> EQ_SETTLED_STATUS) else $error("lock changed under hold");
    a_bypass_state: assert property (EQUALIZER_BYPASS |=>
        CORE_OUT.bypass && !EQ_SETTLED_STATUS) else $error("bypass not applied");
    a_pulse_restart: assert property ((sa && $past(sa) && pf && pl == $past(pl))
        ##1 (sa && pf && $changed(pl)) ##1 (sa && pf && $changed(pl))
        ##1 !EQUALIZER_BYPASS |-> ##1 CORE_OUT.restart) else $error("pulse did not restart");
endmodule : eq_pin_control_properties
bind eq_pin_control eq_pin_control_properties props (.SYS_CLK(SYS_CLK), .RESET_N(RESET_N),
    .BUS_REQ(BUS_REQ), .CHROMA_PIN_IN(CHROMA_PIN_IN), .CHROMA_PIN_OUT(CHROMA_PIN_OUT),
    .POLARITY_PIN_IN(POLARITY_PIN_IN), .POLARITY_PIN_OUT(POLARITY_PIN_OUT),
    .EQ_SETTLED_STATUS(EQ_SETTLED_STATUS), .HOLD_IN(HOLD_IN), .EQUALIZER_BYPASS(EQUALIZER_BYPASS),
    .SERIAL_SELECT(SERIAL_SELECT), .SERIAL_CLK(SERIAL_CLK), .SERIAL_DATA_IN(SERIAL_DATA_IN),
    .CORE_IN(CORE_IN), .CORE_OUT(CORE_OUT));

/* File: test/pin_partner.sv */
`timescale 1ns/1ns
module pin_partner (
    // overrides from the supervisor
    input wire logic c_drv,
    input wire logic c_lvl,
    input wire logic p_drv,
    input wire logic p_lvl,
    input wire logic tie,
    // device outputs
    input wire logic lock,
    input wire eq_pins_pkg::pin_out_s c_out,
    input wire eq_pins_pkg::pin_out_s p_out,
    input wire logic ser_out,
    input wire logic ser_oe,
    // pin levels seen by the device
    output eq_pins_pkg::pin_in_s c_in,
    output eq_pins_pkg::pin_in_s p_in,
    output logic hold,
    output logic ser_sel,
    output logic ser_clk,
    output logic ser_din
);
    // level of a weakly driven pin; undriven shows the inverse
    function automatic eq_pins_pkg::pin_in_s pin(input logic drv, input logic lvl,
        input eq_pins_pkg::pin_out_s o);
        return '{level: drv ? lvl : (o.weak_oe ? o.value : ~o.value), forced: drv};
    endfunction : pin
    // indicator pins
    assign c_in = pin(c_drv, c_lvl, c_out);
    assign p_in = pin(p_drv, p_lvl, p_out);
    // hold low unless strapped to lock
    assign hold = tie & lock;
    // serial select and clock grounded, data in follows the driven data out
    assign ser_sel = 1'b0;
    assign ser_clk = 1'b0;
    assign ser_din = ser_oe & ser_out;
endmodule : pin_partner

/* File: test/test_eq_pin_control.sv */
`timescale 1ns/1ns
module test_eq_pin_control;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    eq_pins_pkg::bus_req_s req = '0;
    eq_pins_pkg::core_in_s core = '0;
    eq_pins_pkg::core_out_s cout;
    eq_pins_pkg::pin_in_s c_in;
    eq_pins_pkg::pin_in_s p_in;
    eq_pins_pkg::pin_out_s c_out;
    eq_pins_pkg::pin_out_s p_out;
    logic [31:0] rdata;
    logic [31:0] v;
    logic irq, lock, hold, ser_sel, ser_clk, ser_din, ser_out, ser_oe;
    logic bypass = 1'b0;
    logic c_drv = 1'b0;
    logic c_lvl = 1'b0;
    logic p_drv = 1'b0;
    logic p_lvl = 1'b0;
    logic tie = 1'b0;
    logic [7:0] ofs [6] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14};
    logic [31:0] rv [6] = '{32'h0, 32'h100, 32'h0, 32'h0, 32'h0, 32'h0};
    int n_mismatch = 0;
    int n_compared = 0;
    // system clock
    always #20 clk = ~clk;
    // device and board
    eq_pin_control uut (.SYS_CLK(clk), .RESET_N(rst_n), .BUS_REQ(req), .BUS_RDATA(rdata),
        .IRQ(irq), .CHROMA_PIN_IN(c_in), .CHROMA_PIN_OUT(c_out), .POLARITY_PIN_IN(p_in),
        .POLARITY_PIN_OUT(p_out), .EQ_SETTLED_STATUS(lock), .HOLD_IN(hold),
        .EQUALIZER_BYPASS(bypass), .SERIAL_SELECT(ser_sel), .SERIAL_CLK(ser_clk),
        .SERIAL_DATA_IN(ser_din), .SERIAL_DATA_OUT(ser_out), .SERIAL_DATA_OE(ser_oe),
        .CORE_IN(core), .CORE_OUT(cout));
    pin_partner board (.c_drv(c_drv), .c_lvl(c_lvl), .p_drv(p_drv), .p_lvl(p_lvl), .tie(tie),
        .lock(lock), .c_out(c_out), .p_out(p_out), .ser_out(ser_out), .ser_oe(ser_oe),
        .c_in(c_in), .p_in(p_in), .hold(hold), .ser_sel(ser_sel), .ser_clk(ser_clk),
        .ser_din(ser_din));
    // verdict
    task automatic end_sim;
        if (n_mismatch == 0 && n_compared > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : end_sim
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        n_compared++;
        if (g !== e) begin
            n_mismatch++;
            $display("[FAIL] %0t got %h expected %h", $time, g, e);
        end
    endtask : chk
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : cyc
    // register port cycles
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        req <= '{a, d, 1'b1, 1'b0};
        @(posedge clk);
        req.wr <= 1'b0;
    endtask : wr
    task automatic rchk(input logic [7:0] a, input logic [31:0] e);
        @(posedge clk);
        req <= '{a, 32'h0, 1'b0, 1'b1};
        @(posedge clk);
        req.rd <= 1'b0;
        #1;
        v = rdata;
        if (e !== 32'hFFFFFFFF) begin
            chk(v, e);
        end
    endtask : rchk
    task automatic wait_lock(input logic e);
        int i;
        for (i = 0; i < 300 && lock !== e; i++) begin
            cyc(1);
        end
        chk(lock, e);
        if (i == 300) begin
            end_sim();
        end
    endtask : wait_lock
    // main sequence
    initial begin
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        for (int k = 0; k < 6; k++) begin
            rchk(ofs[k], rv[k]);
        end
        // released pins report the detectors
        for (int b = 1; b >= 0; b--) begin
            @(posedge clk);
            core.burst_seen <= b[0];
            core.inverted_seen <= b[0];
            cyc(2);
            chk(c_out, {b[0], 1'b1});
            chk(p_out, {b[0], 1'b1});
        end
        // forced pins select the modes
        for (int b = 0; b < 2; b++) begin
            @(posedge clk);
            {c_drv, c_lvl, p_drv, p_lvl} <= {1'b1, b[0], 1'b1, b[0]};
            cyc(2);
            chk({cout.color_mode, cout.invert_chain, c_out.weak_oe, p_out.weak_oe},
                {b[0], b[0], 2'h0});
        end
        @(posedge clk);
        {c_drv, p_drv} <= 2'h0;
        core.signal_present <= 1'b1;
        core.adapt_done <= 1'b1;
        // settle time, lock and interrupt
        cyc(50);
        chk(lock, 1'b0);
        wr(8'h08, 32'hF);
        wait_lock(1'b1);
        rchk(8'h04, 32'h804);
        chk(irq, 1'b0);
        rchk(8'h08, 32'h1);
        wr(8'h0C, 32'h1);
        cyc(1);
        chk(irq, 1'b1);
        wr(8'h08, 32'h1);
        cyc(1);
        chk(irq, 1'b0);
        // polarity pulse reacquires
        @(posedge clk);
        {p_drv, p_lvl} <= 2'b10;
        @(posedge clk);
        p_lvl <= 1'b1;
        @(posedge clk);
        p_lvl <= 1'b0;
        for (int k = 0; k < 6 && cout.restart !== 1'b1; k++) begin
            cyc(1);
        end
        chk({cout.restart, lock}, 2'b10);
        p_drv <= 1'b0;
        rchk(8'h10, 32'h1);
        rchk(8'h08, 32'hFFFFFFFF);
        chk(v[2], 1'b1);
        wr(8'h08, 32'hF);
        // hold strapped to lock
        wait_lock(1'b1);
        @(posedge clk);
        tie <= 1'b1;
        @(posedge clk);
        core.adapt_done <= 1'b0;
        cyc(5);
        chk({lock, cout.adapt_en}, 2'b10);
        tie <= 1'b0;
        cyc(3);
        chk(lock, 1'b0);
        core.adapt_done <= 1'b1;
        // bypass
        wait_lock(1'b1);
        @(posedge clk);
        bypass <= 1'b1;
        cyc(2);
        chk({cout.bypass, lock}, 2'b10);
        rchk(8'h04, 32'h1040);
        bypass <= 1'b0;
        cyc(2);
        chk(cout.bypass, 1'b0);
        wait_lock(1'b1);
        // software hold, then software restart
        wr(8'h00, 32'h2);
        cyc(1);
        chk({cout.adapt_en, ser_out, ser_oe}, 3'h0);
        rchk(8'h04, 32'h824);
        wr(8'h00, 32'h1);
        rchk(8'h10, 32'h2);
        chk(lock, 1'b0);
        wait_lock(1'b1);
        // loss of signal
        @(posedge clk);
        core.signal_present <= 1'b0;
        cyc(2);
        chk(lock, 1'b0);
        end_sim();
    end
endmodule : test_eq_pin_control
